// ===== common/ccd_pkg.sv
// Package of constants for the compare, decrement and decimal adjust execution block.
// Assumes a byte-wide core with a 64-entry file register space.
package ccd_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [7:0] FILE_RESET = 8'h00;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [7:0] BCD_LOW_FIX = 8'h06;
    localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [1:0] SKIP_CYCLES = 2'h2;
    typedef enum logic [3:0]
    {
        CCD_OP_NONE = 4'h1,
        CCD_OP_CMP = 4'h2,
        CCD_OP_DEC = 4'h4,
        CCD_OP_DECSZ = 4'h8
    } ccd_op_t;
    typedef enum logic [1:0]
    {
        CCD_ST_RUN = 2'h1,
        CCD_ST_NOP = 2'h2
    } ccd_state_t;
endpackage

// ===== core/ccd_decimal_adjust.sv
// Decimal adjust of a byte after an addition, purely combinational.
// Assumes the carry and digit carry of the preceding addition are supplied.
`timescale 1ns/1ps
module ccd_decimal_adjust
(
    input wire logic [7:0] value_in,
    input wire logic carry_in,
    input wire logic digit_carry_in,
    output logic [7:0] value_out,
    output logic carry_out
);
    logic [8:0] step;
    always_comb
    begin
        step = {1'b0, value_in};
        if (digit_carry_in || (value_in[3:0] > ccd_pkg::BCD_DIGIT_MAX))
        begin
            step = step + {1'b0, ccd_pkg::BCD_LOW_FIX};
        end
        carry_out = carry_in || step[8] || (step[7:4] > ccd_pkg::BCD_DIGIT_MAX);
        if (carry_out)
        begin
            step = {1'b0, step[7:0]} + {1'b0, ccd_pkg::BCD_HIGH_FIX};
        end
        value_out = step[7:0];
    end
endmodule

// ===== core/ccd_exec.sv
// Execution unit for compare, decrement, decrement-skip and decimal adjust.
// Assumes the decoder presents one instruction per cycle on op_valid and the
// file register operand on file_data in the same cycle.
// Functional notes
// - Compare computes file minus working register; flags only, no write-back.
// - Compare finishes in one cycle and never skips.
// - Decrement writes file minus one to working or file register, only null flag.
// - Decrement-skip stores file minus one to working or file register by target bit.
// - Decrement-skip with zero result discards next instruction, two cycles total.
// - Decimal adjust converts working register to packed decimal, only borrow flag.
`timescale 1ns/1ps
module ccd_exec
#(
    parameter int DATA_W = ccd_pkg::DATA_W,
    parameter int ADDR_W = ccd_pkg::ADDR_W
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic op_compare_working_with_file,
    input wire logic op_file_decrement,
    input wire logic op_file_decrement_skip_if_null,
    input wire logic op_decimal_adjust,
    input wire logic [ADDR_W-1:0] file_addr,
    input wire logic writeback_target,
    input wire logic [DATA_W-1:0] file_data,
    input wire logic digit_carry_in,
    output logic [DATA_W-1:0] working_register,
    output logic result_null_flag,
    output logic borrow_out_flag,
    output logic file_we,
    output logic [ADDR_W-1:0] file_we_addr,
    output logic [DATA_W-1:0] file_wdata,
    output logic skip_discard,
    output logic busy
);
    ccd_pkg::ccd_state_t state;
    ccd_pkg::ccd_state_t next_state;
    logic [DATA_W-1:0] next_working_register;
    logic next_result_null_flag;
    logic next_borrow_out_flag;
    logic next_file_we;
    logic [ADDR_W-1:0] next_file_we_addr;
    logic [DATA_W-1:0] next_file_wdata;
    logic next_skip_discard;
    logic next_busy;
    logic [DATA_W:0] diff;
    logic [DATA_W-1:0] dec_value;
    logic [DATA_W-1:0] adj_value;
    logic adj_carry;
    logic accept;

    // Decimal adjust serves exactly two packed digits, so only a byte datapath is accepted.
    if ((DATA_W != 32'h8) || (ADDR_W < 32'h1))
    begin : g_width_check
        $error("Unsupported width parameters for the execution unit.");
    end

    ccd_decimal_adjust u_adjust
    (
        .value_in(working_register),
        .carry_in(borrow_out_flag),
        .digit_carry_in(digit_carry_in),
        .value_out(adj_value),
        .carry_out(adj_carry)
    );

    always_comb
    begin
        diff = {1'b0, file_data} - {1'b0, working_register};
        dec_value = file_data - ccd_pkg::ONE;
        accept = op_valid && (state == ccd_pkg::CCD_ST_RUN);
        next_state = ccd_pkg::CCD_ST_RUN;
        next_working_register = working_register;
        next_result_null_flag = result_null_flag;
        next_borrow_out_flag = borrow_out_flag;
        next_file_we = 1'b0;
        next_file_we_addr = file_addr;
        next_file_wdata = dec_value;
        next_skip_discard = 1'b0;
        next_busy = 1'b0;
        case (state)
            ccd_pkg::CCD_ST_RUN:
            begin
                if (accept && op_compare_working_with_file)
                begin
                    next_result_null_flag = (diff[7:0] == 8'h00);
                    next_borrow_out_flag = ~diff[8];
                end
                else if (accept && (op_file_decrement || op_file_decrement_skip_if_null))
                begin
                    next_result_null_flag = (dec_value == 8'h00);
                    if (writeback_target)
                    begin
                        next_file_we = 1'b1;
                    end
                    else
                    begin
                        next_working_register = dec_value;
                    end
                    if (op_file_decrement_skip_if_null && (dec_value == 8'h00))
                    begin
                        next_skip_discard = 1'b1;
                        next_busy = 1'b1;
                        next_state = ccd_pkg::CCD_ST_NOP;
                    end
                end
                else if (accept && op_decimal_adjust)
                begin
                    // The adjust trusts the prior addition
                    next_working_register = adj_value;
                    next_borrow_out_flag = adj_carry;
                end
            end
            ccd_pkg::CCD_ST_NOP:
            begin
                // The fetched slot is burned here as a no-operation.
                next_state = ccd_pkg::CCD_ST_RUN;
            end
            default:
            begin
                next_state = ccd_pkg::CCD_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state <= ccd_pkg::CCD_ST_RUN;
            working_register <= ccd_pkg::WORK_RESET;
            result_null_flag <= 1'b0;
            borrow_out_flag <= 1'b0;
            file_we <= 1'b0;
            file_we_addr <= {ADDR_W{1'b0}};
            file_wdata <= ccd_pkg::FILE_RESET;
            skip_discard <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            working_register <= next_working_register;
            result_null_flag <= next_result_null_flag;
            borrow_out_flag <= next_borrow_out_flag;
            file_we <= next_file_we;
            file_we_addr <= next_file_we_addr;
            file_wdata <= next_file_wdata;
            skip_discard <= next_skip_discard;
            busy <= next_busy;
        end
    end

    sequence cmp_issue_s;
        op_valid && !busy && op_compare_working_with_file;
    endsequence

    sequence dsz_zero_s;
        op_valid && !busy && !op_compare_working_with_file && !op_file_decrement
            && op_file_decrement_skip_if_null && (file_data == 8'h01);
    endsequence

    sequence dec_issue_s;
        op_valid && !busy && !op_compare_working_with_file && op_file_decrement;
    endsequence

    sequence dsz_issue_s;
        op_valid && !busy && !op_compare_working_with_file && !op_file_decrement
            && op_file_decrement_skip_if_null;
    endsequence

    // A byte that is already packed decimal with no carries must pass through untouched.
    sequence adj_plain_s;
        op_valid && !busy && op_decimal_adjust && !op_compare_working_with_file
            && !op_file_decrement && !op_file_decrement_skip_if_null && !digit_carry_in
            && !borrow_out_flag && (working_register[3:0] <= ccd_pkg::BCD_DIGIT_MAX)
            && (working_register[7:4] <= ccd_pkg::BCD_DIGIT_MAX);
    endsequence

    cmp_no_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmp_issue_s |=> !file_we && $stable(working_register))
        else $error("Compare wrote a result.");
    cmp_no_skip_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmp_issue_s |=> !skip_discard && !busy)
        else $error("Compare skipped.");
    cmp_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
        cmp_issue_s |=> (borrow_out_flag == ($past(file_data) >= $past(working_register)))
            && (result_null_flag == ($past(file_data) == $past(working_register))))
        else $error("Compare flags wrong.");
    dec_file_a: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && !busy && !op_compare_working_with_file && op_file_decrement
            && writeback_target |=> file_we && (file_wdata == $past(file_data) - 8'h01)
            && $stable(borrow_out_flag))
        else $error("Decrement to file wrong.");
    dsz_work_a: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && !busy && !op_compare_working_with_file && !op_file_decrement
            && op_file_decrement_skip_if_null && !writeback_target
            |=> !file_we && (working_register == $past(file_data) - 8'h01))
        else $error("Decrement-skip to working register wrong.");
    dsz_skip_a: assert property (@(posedge clk_sys) disable iff (rst)
        dsz_zero_s |=> skip_discard && busy ##1 !busy && !skip_discard)
        else $error("Skip not taken for exactly two cycles.");
    adj_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && !busy && op_decimal_adjust && !op_compare_working_with_file
            && !op_file_decrement && !op_file_decrement_skip_if_null
            |=> $stable(result_null_flag) && !file_we && !skip_discard)
        else $error("Decimal adjust touched other state.");
    dec_null_a: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && !busy && !op_compare_working_with_file && op_file_decrement
            |=> result_null_flag == ($past(file_data) == 8'h01))
        else $error("Decrement null flag wrong.");
    dec_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
        dec_issue_s ##0 writeback_target |=> file_we && (file_we_addr == $past(file_addr)))
        else $error("Decrement wrote the wrong file address.");
    dec_one_cycle_a: assert property (@(posedge clk_sys) disable iff (rst)
        dec_issue_s |=> !busy && !skip_discard)
        else $error("Plain decrement took more than one cycle.");
    dsz_file_a: assert property (@(posedge clk_sys) disable iff (rst)
        dsz_issue_s ##0 writeback_target |=> file_we && (file_we_addr == $past(file_addr))
            && (file_wdata == $past(file_data) - 8'h01) && $stable(working_register))
        else $error("Decrement-skip to file register wrong.");
    dsz_no_skip_a: assert property (@(posedge clk_sys) disable iff (rst)
        dsz_issue_s ##0 (file_data != 8'h01) |=> !skip_discard && !busy)
        else $error("Decrement-skip skipped on a nonzero result.");
    busy_refuse_a: assert property (@(posedge clk_sys) disable iff (rst)
        busy |=> !busy && !file_we && !skip_discard && $stable(working_register)
            && $stable(result_null_flag) && $stable(borrow_out_flag))
        else $error("An instruction ran in the discarded slot.");
    adj_plain_a: assert property (@(posedge clk_sys) disable iff (rst)
        adj_plain_s |=> $stable(working_register) && !borrow_out_flag)
        else $error("Decimal adjust changed a valid packed decimal value.");
endmodule

// ===== tb/ccd_file_model.sv
// File register partner model: 64 byte cells, read at once, written on the pulse.
// Assumes the bench preloads a cell by hierarchical access before each operation.
`timescale 1ns/1ps
module ccd_file_model
(
    input wire logic clk_sys,
    input wire logic [5:0] file_addr,
    input wire logic file_we,
    input wire logic [5:0] file_we_addr,
    input wire logic [7:0] file_wdata,
    output logic [7:0] file_data
);
    logic [7:0] mem [64];
    assign file_data = mem[file_addr];
    // A plain always keeps the bench's preload legal beside the write port.
    always @(posedge clk_sys)
    begin
        if (file_we)
        begin
            mem[file_we_addr] <= file_wdata;
        end
    end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the execution unit, with a byte model kept in integers.
// Assumes one design instance fed by a file register model.
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ov = 1'b0, oc = 1'b0, od = 1'b0, os = 1'b0, oa = 1'b0, wt = 1'b0, dc = 1'b0;
    logic [5:0] fa = 6'h00, fwa;
    logic [7:0] fd, wr, fwd;
    logic z, c, fwe, skd, bsy;
    int error_cnt = 0, total_checks = 0, w = 0, zm = 0, cm = 0, i, v;
    int s = 0, e = 0, hc = 0;
    logic [7:0] pa, pb;
    ccd_exec ccd_exec_inst (.clk_sys(clk_sys), .rst(rst), .op_valid(ov),
        .op_compare_working_with_file(oc), .op_file_decrement(od),
        .op_file_decrement_skip_if_null(os), .op_decimal_adjust(oa), .file_addr(fa),
        .writeback_target(wt), .file_data(fd), .digit_carry_in(dc), .working_register(wr),
        .result_null_flag(z), .borrow_out_flag(c), .file_we(fwe), .file_we_addr(fwa),
        .file_wdata(fwd), .skip_discard(skd), .busy(bsy));
    ccd_file_model ccd_file_model_inst (.clk_sys(clk_sys), .file_addr(fa), .file_we(fwe),
        .file_we_addr(fwa), .file_wdata(fwd), .file_data(fd));
    initial forever #4 clk_sys = ~clk_sys;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task op(input int k, input logic [5:0] a, input logic t, input logic [7:0] r,
        input logic h);
        int d, we, sk;
        ccd_file_model_inst.mem[a] = r;
        {oc, od, os, oa} = {k == 0, k == 1, k == 2, k == 3};
        fa = a;
        wt = t;
        dc = h;
        ov = 1'b1;
        d = w;
        if (k == 0)
        begin
            zm = (r == w);
            cm = (r >= w);
        end
        else if (k == 3)
        begin
            if (w % 16 > 9 || dc) d = d + 6;
            cm = (w > 'h99 || cm);
            w = (d + (cm ? 'h60 : 0)) % 256;
        end
        else
        begin
            d = (r + 255) % 256;
            zm = (d == 0);
            if (!t) w = d;
        end
        we = (k == 1 || k == 2) && t;
        sk = (k == 2 && d == 0);
        @(posedge clk_sys) #1;
        chk(wr, w[7:0]);
        chk({7'h00, z}, zm[7:0]);
        chk({7'h00, c}, cm[7:0]);
        chk({7'h00, fwe}, we[7:0]);
        if (we) chk(fwd, d[7:0]);
        if (we) chk({2'h0, fwa}, {2'h0, a});
        chk({6'h00, skd, bsy}, {6'h00, sk[0], sk[0]});
        if (sk)
        begin
            {oc, od, os} = 3'b010;
            @(posedge clk_sys) #1;
            chk({5'h00, skd, bsy, fwe}, 8'h00);
            chk(wr, w[7:0]);
            chk({7'h00, z}, zm[7:0]);
        end
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #20000;
        error_cnt++;
        end_of_test();
    end
    initial
    begin
        v = $urandom(32'h3882a88b);
        repeat (12) @(posedge clk_sys);
        #1 rst = 1'b0;
        chk(wr, 8'h00);
        chk({3'h0, z, c, fwe, skd, bsy}, 8'h00);
        for (i = 0; i < 12; i++)
        begin
            op(1, 6'($urandom), 1'b0, 8'($urandom), 1'($urandom));
            v = (i % 3 == 0) ? w : $urandom % 256;
            op(0, 6'h3f, 1'b0, v[7:0], 1'($urandom));
        end
        $display("compare test done");
        for (i = 0; i < 8; i++)
        begin
            op(1, 6'(i), 1'(i), 8'(i < 4 ? i : $urandom), 1'($urandom));
        end
        $display("decrement test done");
        for (i = 0; i < 8; i++)
        begin
            op(2, 6'(i), 1'(i), 8'(i < 4 ? 1 : $urandom), 1'($urandom));
        end
        $display("decrement skip test done");
        for (i = 0; i < 10; i++)
        begin
            pa = {4'($urandom % 10), 4'(1 + $urandom % 9)};
            pb = {4'($urandom % 10), 4'($urandom % 10)};
            s = pa + pb;
            hc = (pa[3:0] + pb[3:0] > 15);
            e = pa[7:4] * 10 + pa[3:0] + pb[7:4] * 10 + pb[3:0];
            // Working register and both carries are left as a packed decimal addition leaves them.
            op(1, 6'h00, 1'b0, 8'(s + 1), 1'b0);
            op(0, 6'h02, 1'b0, (s > 255) ? 8'hff : 8'h00, 1'b0);
            op(3, 6'h01, 1'b0, 8'h00, 1'(hc));
            chk(wr, 8'((e % 100) / 10 * 16 + e % 10));
            chk({7'h00, c}, 8'(e > 99));
        end
        ov = 1'b0;
        $display("decimal adjust test done");
        end_of_test();
    end
endmodule
